/* File: rtl/npic_defs.svh */
// Offsets, field positions, reset values and sizes of the interrupt controller
`ifndef NPIC_DEFS_SVH
`define NPIC_DEFS_SVH
`define NPIC_NSRC        154
`define NPIC_NWORD       5
`define NPIC_NEST        8
`define NPIC_ADDR_W      12
`define NPIC_OFF_CTRL    12'h000
`define NPIC_OFF_GROUP   12'h004
`define NPIC_OFF_THRESH  12'h008
`define NPIC_OFF_VBASE   12'h00C
`define NPIC_OFF_STATUS  12'h010
`define NPIC_OFF_ENSET   12'h040
`define NPIC_OFF_ENCLR   12'h060
`define NPIC_OFF_PNDSET  12'h080
`define NPIC_OFF_PNDCLR  12'h0A0
`define NPIC_OFF_PRIO    12'h400
`define NPIC_BIT_GATE    0
`define NPIC_BIT_SRAM    1
`define NPIC_PRIO_HI     7
`define NPIC_PRIO_LO     5
`define NPIC_VBASE_LO    10
`define NPIC_RST_CTRL    2'h0
`define NPIC_RST_GROUP   2'h0
`define NPIC_RST_THRESH  3'h0
`define NPIC_RST_VBASE   22'h000000
`define NPIC_RST_PRIO    3'h0
`define NPIC_IDLE_LVL    4'h8
`endif

/* File: rtl/npic_pkg.sv */
// Types shared by the interrupt controller and its users
package npic_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } npic_bus_t;

  typedef struct packed {
    logic       ack;
    logic       exit;
    logic       stack_done;
    logic       vvalid;
    logic [31:0] vdata;
  } npic_core_in_t;

  typedef enum logic [1:0] {
    NPIC_IDLE,
    NPIC_STACK,
    NPIC_FETCH
  } npic_state_t;
endpackage : npic_pkg

/* File: rtl/npic_ctrl.sv */
// Nested prioritised vectored interrupt controller with register port
//
// Notes on behaviour
// (RQ1) 154 sources resolved over eight levels
// (RQ2) Per-source masks plus global gate, independent
// (RQ3) Handler address handed to core directly
// (RQ4) Higher priority served first and preempts lower
// (RQ5) Software splits priority into preempt/sub parts
// (RQ6) Equal preempt level never preempts; tail chains
// (RQ7) Equal priority ties go to lowest number
// (RQ8) Nesting tracked; thread return only when idle
// (RQ9) Disabled source never reaches the core
// (RQ10) Flash table: stacking and fetch run together
// (RQ11) SRAM table: stacking then fetch, sequentially
// (RQ12) Software keeps vector base 1 kB aligned
// (RQ13) Software enables only sources with handlers
// (RQ14) Enables set, cleared, read back individually
// (RQ15) Closed gate lets only the NMI through
// (RQ16) Eight-bit priority, upper three bits used
// (RQ17) Smaller value means more urgent, 0 highest
// (RQ18) Pend clear discards unserviced requests
// (RQ19) Software can pend a source by write
// (RQ20) Threshold blocks priority at or above it
// (RQ21) Entering handler clears that source pending
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
`include "npic_defs.svh"

module npic_ctrl (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire npic_pkg::npic_bus_t    bus_i,
  output logic [31:0]                 rdata_o,
  input  wire logic [`NPIC_NSRC-1:0]  src_i,
  input  wire logic                   nmi_i,
  input  wire npic_pkg::npic_core_in_t core_i,
  output logic                        irq_o,
  output logic [7:0]                  irq_num_o,
  output logic                        tail_chain_o,
  output logic                        thread_ok_o,
  output logic                        nmi_o,
  output logic                        stack_o,
  output logic                        vfetch_o,
  output logic [31:0]                 vaddr_o,
  output logic [31:0]                 handler_o,
  output logic                        handler_valid_o
);
  import npic_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Preemption part of a level; idle level stays above every real one
  function automatic logic [3:0] preempt(input logic [3:0] lvl, input logic [1:0] sub);
    preempt = (lvl == `NPIC_IDLE_LVL) ? lvl : (lvl & ~((4'h1 << sub) - 4'h1));
  endfunction : preempt

  function automatic logic in_block(input logic [11:0] a, input logic [11:0] base);
    in_block = (a >= base) && (a < base + 12'(4 * `NPIC_NWORD));
  endfunction : in_block

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [`NPIC_NSRC-1:0] src_s1;
  logic [`NPIC_NSRC-1:0] src_s2;
  logic                  nmi_s1;
  logic                  nmi_s2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_s1 <= '0;
      src_s2 <= '0;
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
    end else begin
      src_s1 <= src_i;
      src_s2 <= src_s1;
      nmi_s1 <= nmi_i;
      nmi_s2 <= nmi_s1;
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0]            ctrl;
  logic [1:0]            group;
  logic [2:0]            thresh;
  logic [21:0]           vbase;
  logic [`NPIC_NSRC-1:0] enable;
  logic [`NPIC_NSRC-1:0] pending;
  logic [2:0]            prio [`NPIC_NSRC];
  logic [3:0]            depth;
  logic [7:0]            act_src [`NPIC_NEST];
  logic [2:0]            act_pri [`NPIC_NEST];
  npic_state_t           state;
  logic                  req_q;
  logic [7:0]            win_q;
  logic [2:0]            winp_q;
  wire [11:0] a        = bus_i.addr;
  wire [2:0]  word     = 3'((a[11:2]) & 10'h7);
  wire        accept   = core_i.ack && req_q && !core_i.exit && (state == NPIC_IDLE);
  wire [`NPIC_NSRC-1:0] wmask = `NPIC_NSRC'(bus_i.wdata) << (32 * word);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl   <= `NPIC_RST_CTRL;
      group  <= `NPIC_RST_GROUP;
      thresh <= `NPIC_RST_THRESH;
      vbase  <= `NPIC_RST_VBASE;
    end else if (bus_i.wr) begin
      case (a)
        `NPIC_OFF_CTRL:   ctrl   <= bus_i.wdata[1:0];     // [RQ2]
        `NPIC_OFF_GROUP:  group  <= bus_i.wdata[1:0];     // [RQ5]
        `NPIC_OFF_THRESH: thresh <= bus_i.wdata[`NPIC_PRIO_HI:`NPIC_PRIO_LO];
        `NPIC_OFF_VBASE:  vbase  <= bus_i.wdata[31:`NPIC_VBASE_LO]; // [RQ12]
        default: ;
      endcase
    end
  end

  // Enables: set and clear words keep the gate and other bits untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= '0;
    end else if (bus_i.wr && in_block(a, `NPIC_OFF_ENSET)) begin
      enable <= enable | wmask;                           // [RQ14]
    end else if (bus_i.wr && in_block(a, `NPIC_OFF_ENCLR)) begin
      enable <= enable & ~wmask;                          // [RQ14]
    end
  end

  // Pending: a hardware or software set wins over any clear
  logic [`NPIC_NSRC-1:0] pnd_set;
  logic [`NPIC_NSRC-1:0] pnd_clr;
  always_comb begin
    pnd_set = src_s2;
    pnd_clr = '0;
    if (bus_i.wr && in_block(a, `NPIC_OFF_PNDSET)) begin
      pnd_set = pnd_set | wmask;                          // [RQ19]
    end
    if (bus_i.wr && in_block(a, `NPIC_OFF_PNDCLR)) begin
      pnd_clr = wmask;                                    // [RQ18]
    end
    if (accept) begin
      pnd_clr[win_q] = 1'b1;                              // [RQ21]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~pnd_clr) | pnd_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `NPIC_NSRC; i++) begin
        prio[i] <= `NPIC_RST_PRIO;
      end
    end else if (bus_i.wr && a >= `NPIC_OFF_PRIO
                 && a < `NPIC_OFF_PRIO + 12'(4 * `NPIC_NSRC)) begin
      prio[8'((a - `NPIC_OFF_PRIO) >> 2)] <= bus_i.wdata[`NPIC_PRIO_HI:`NPIC_PRIO_LO]; // [RQ16]
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [3:0] best_p;
  logic [7:0] best_i;
  logic [3:0] run_lvl;
  // Linear scan keeps the first of equal levels, so low numbers win
  always_comb begin
    best_p = `NPIC_IDLE_LVL;
    best_i = 8'h00;
    for (int i = 0; i < `NPIC_NSRC; i++) begin
      if (pending[i] && enable[i]                         // [RQ9]
          && (thresh == 3'h0 || prio[i] < thresh)          // [RQ20]
          && {1'b0, prio[i]} < best_p) begin               // [RQ17] [RQ7] [RQ1]
        best_p = {1'b0, prio[i]};
        best_i = 8'(i);
      end
    end
  end

  always_comb begin
    run_lvl = `NPIC_IDLE_LVL;
    if (depth != 4'h0) begin
      run_lvl = {1'b0, act_pri[3'(depth - 4'h1)]};
    end
  end

  // Strict compare: same preempt level must wait for the handler to end
  wire win_ok = preempt(best_p, group) < preempt(run_lvl, group);  // [RQ4] [RQ6]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q  <= 1'b0;
      win_q  <= 8'h00;
      winp_q <= 3'h0;
    end else begin
      req_q  <= win_ok && ctrl[`NPIC_BIT_GATE] && !accept; // [RQ2] [RQ15]
      win_q  <= best_i;
      winp_q <= best_p[2:0];
    end
  end

  assign irq_o     = req_q;
  assign irq_num_o = win_q;

  // ----------------------------------------------------------------
  // Nesting
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth <= 4'h0;
      for (int i = 0; i < `NPIC_NEST; i++) begin
        act_src[i] <= 8'h00;
        act_pri[i] <= 3'h0;
      end
    end else if (core_i.exit && depth != 4'h0) begin
      depth <= depth - 4'h1;                              // [RQ8]
    end else if (accept) begin
      act_src[depth[2:0]] <= win_q;
      act_pri[depth[2:0]] <= winp_q;
      depth               <= depth + 4'h1;                // [RQ8]
    end
  end

  // Tail chain: judged against the level left once this handler returns
  wire [3:0] exit_lvl = (depth > 4'h1) ? {1'b0, act_pri[3'(depth - 4'h2)]} : `NPIC_IDLE_LVL;
  wire       exit_ok  = preempt(best_p, group) < preempt(exit_lvl, group);
  assign tail_chain_o = core_i.exit && exit_ok && ctrl[`NPIC_BIT_GATE];   // [RQ6]
  assign thread_ok_o  = (depth == 4'h0) && !req_q;                        // [RQ8]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_o <= 1'b0;
    end else begin
      nmi_o <= nmi_s2;                                    // [RQ15]
    end
  end

  // ----------------------------------------------------------------
  // Entry sequence: stacking and vector fetch
  // ----------------------------------------------------------------
  logic stk_ok;
  logic vec_ok;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state           <= NPIC_IDLE;
      stack_o         <= 1'b0;
      vfetch_o        <= 1'b0;
      vaddr_o         <= 32'h0000_0000;
      handler_o       <= 32'h0000_0000;
      handler_valid_o <= 1'b0;
      stk_ok          <= 1'b0;
      vec_ok          <= 1'b0;
    end else begin
      stack_o         <= 1'b0;
      vfetch_o        <= 1'b0;
      handler_valid_o <= 1'b0;
      case (state)
        NPIC_IDLE: begin
          stk_ok <= 1'b0;
          vec_ok <= 1'b0;
          if (accept) begin
            stack_o <= 1'b1;
            // Table base is 1 kB aligned, so the index is simply ORed in
            vaddr_o <= {vbase, win_q, 2'b00};             // [RQ3] [RQ12]
            if (ctrl[`NPIC_BIT_SRAM]) begin
              state <= NPIC_STACK;                        // [RQ11]
            end else begin
              vfetch_o <= 1'b1;                           // [RQ10]
              state    <= NPIC_FETCH;
            end
          end
        end
        NPIC_STACK: begin
          if (core_i.stack_done) begin
            stk_ok   <= 1'b1;
            vfetch_o <= 1'b1;                             // [RQ11]
            state    <= NPIC_FETCH;
          end
        end
        NPIC_FETCH: begin
          if (core_i.stack_done) begin
            stk_ok <= 1'b1;
          end
          if (core_i.vvalid) begin
            vec_ok    <= 1'b1;
            handler_o <= core_i.vdata;                    // [RQ3]
          end
          if ((stk_ok || core_i.stack_done) && (vec_ok || core_i.vvalid)) begin
            handler_valid_o <= 1'b1;
            state           <= NPIC_IDLE;
          end
        end
        default: state <= NPIC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port: data one cycle after the strobe
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (in_block(a, `NPIC_OFF_ENSET) || in_block(a, `NPIC_OFF_ENCLR)) begin
      next_rdata = 32'(enable >> (32 * word));            // [RQ14]
    end else if (in_block(a, `NPIC_OFF_PNDSET) || in_block(a, `NPIC_OFF_PNDCLR)) begin
      next_rdata = 32'(pending >> (32 * word));
    end else if (a >= `NPIC_OFF_PRIO && a < `NPIC_OFF_PRIO + 12'(4 * `NPIC_NSRC)) begin
      next_rdata = {24'h000000, prio[8'((a - `NPIC_OFF_PRIO) >> 2)], 5'h00}; // [RQ16]
    end else begin
      case (a)
        `NPIC_OFF_CTRL:   next_rdata = {30'h0, ctrl};
        `NPIC_OFF_GROUP:  next_rdata = {30'h0, group};
        `NPIC_OFF_THRESH: next_rdata = {24'h0, thresh, 5'h00};
        `NPIC_OFF_VBASE:  next_rdata = {vbase, 10'h000};
        `NPIC_OFF_STATUS: next_rdata = {15'h0, req_q, act_src[3'(depth - 4'h1)], 4'h0, depth};
        default:          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= bus_i.rd ? next_rdata : 32'h0000_0000;
    end
  end
endmodule : npic_ctrl

/* File: tb/npic_core_model.sv */
// Core stand-in: takes requests, stacks, answers vector reads
`timescale 1ns/10ps
module npic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        irq_i,
  input  wire logic        stack_i,
  input  wire logic        vfetch_i,
  input  wire logic [31:0] vaddr_i,
  input  wire logic        slow_i,
  input  wire logic        exit_i,
  output npic_pkg::npic_core_in_t core_o
);
  import npic_pkg::*;
  logic [3:0]  busy;
  logic [2:0]  sd;
  logic [2:0]  vf;
  logic [31:0] va;
  logic        take;
  // No new entry while one is in flight or a return is going on
  assign take = irq_i && busy == 4'h0 && !exit_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_o <= '0;
      busy   <= 4'h0;
      sd     <= 3'h0;
      vf     <= 3'h0;
      va     <= 32'h0;
    end else begin
      core_o.ack        <= take;
      core_o.exit       <= exit_i;
      core_o.stack_done <= sd == 3'h1;
      core_o.vvalid     <= vf == 3'h1;
      // Every slot holds a handler; idle data toggles
      core_o.vdata <= vf == 3'h1 ? va ^ 32'h5A5A_0000 : ~core_o.vdata;
      busy <= take ? 4'hF : busy - {3'h0, busy != 4'h0};
      sd   <= stack_i ? (slow_i ? 3'h5 : 3'h1) : sd - {2'h0, sd != 3'h0};
      vf   <= vfetch_i ? (slow_i ? 3'h3 : 3'h1) : vf - {2'h0, vf != 3'h0};
      if (vfetch_i) begin
        va <= vaddr_i;
      end
    end
  end
endmodule : npic_core_model

/* File: tb/npic_ctrl_props.sv */
// Port-level assertions for the interrupt controller
`timescale 1ns/10ps
module npic_ctrl_props (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire npic_pkg::npic_bus_t     bus_i,
  input wire logic [31:0]             rdata_o,
  input wire logic                    nmi_i,
  input wire npic_pkg::npic_core_in_t core_i,
  input wire logic                    irq_o,
  input wire logic [7:0]              irq_num_o,
  input wire logic                    tail_chain_o,
  input wire logic                    thread_ok_o,
  input wire logic                    nmi_o,
  input wire logic                    stack_o,
  input wire logic                    vfetch_o,
  input wire logic [31:0]             vaddr_o,
  input wire logic [31:0]             handler_o,
  input wire logic                    handler_valid_o
);
  import npic_pkg::*;
  logic [31:0] last_v;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (core_i.vvalid) begin
      last_v <= core_i.vdata;
    end
  end
  sequence s_take;
    core_i.ack && irq_o && !core_i.exit;
  endsequence
  sequence s_entry;
    stack_o && !irq_o;
  endsequence
  rd_quiet_a: assert property (!bus_i.rd |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  take_stack_a: assert property (s_take |=> s_entry)
    else $error("accepted request not entered");
  take_vec_a: assert property (s_take |=> vaddr_o[9:2] == $past(irq_num_o))
    else $error("vector address not of winner");
  sram_seq_a: assert property (vfetch_o && !stack_o |-> $past(core_i.stack_done))
    else $error("late vector read not after stacking");
  hval_data_a: assert property (handler_valid_o |-> handler_o == last_v)
    else $error("handler differs from vector");
  nmi_lat_a: assert property ($rose(nmi_i) |-> ##3 nmi_o)
    else $error("nmi not passed");
  thread_ret_a: assert property (irq_o || stack_o |-> !thread_ok_o)
    else $error("thread return while busy");
  tail_exit_a: assert property (tail_chain_o |-> core_i.exit)
    else $error("tail chain without exit");
  tail_chain_a: assert property (tail_chain_o |-> ##[1:2] irq_o)
    else $error("tail chain not followed by request");
endmodule : npic_ctrl_props

bind npic_ctrl npic_ctrl_props i_props (
  .clk_i, .rst_i, .bus_i, .rdata_o, .nmi_i, .core_i, .irq_o, .irq_num_o,
  .tail_chain_o, .thread_ok_o, .nmi_o, .stack_o, .vfetch_o, .vaddr_o,
  .handler_o, .handler_valid_o
);

/* File: tb/test_npic_ctrl.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
`include "npic_defs.svh"
module test_npic_ctrl;
  import npic_pkg::*;
  localparam logic [11:0] ES = `NPIC_OFF_ENSET;
  localparam logic [11:0] PS = `NPIC_OFF_PNDSET;
  logic          clk_i;
  logic          rst_i;
  npic_bus_t     bus;
  npic_core_in_t core;
  logic [153:0]  src;
  logic [31:0]   rdata, hnd, vaddr, vbase, r, served[$];
  logic [7:0]    num;
  logic          nmi, nmi_o, irq, tail, tok, stk, vf, hv, slow, exit_r, tail_seen;
  int            fails, n_tests, seed, w, i, j;
  npic_ctrl i_dut (
    .clk_i, .rst_i, .bus_i(bus), .rdata_o(rdata), .src_i(src), .nmi_i(nmi),
    .core_i(core), .irq_o(irq), .irq_num_o(num), .tail_chain_o(tail),
    .thread_ok_o(tok), .nmi_o, .stack_o(stk), .vfetch_o(vf), .vaddr_o(vaddr),
    .handler_o(hnd), .handler_valid_o(hv)
  );
  npic_core_model i_core (
    .clk_i, .rst_i, .irq_i(irq), .stack_i(stk), .vfetch_i(vf), .vaddr_i(vaddr),
    .slow_i(slow), .exit_i(exit_r), .core_o(core)
  );
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (hv) served.push_back(hnd);
    if (tail) tail_seen = 1'b1;
  end
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_i);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rc
  task automatic pend(input int n);
    wr(PS + 12'(n / 32 * 4), 32'h1 << (n % 32));
  endtask : pend
  task automatic cfg(input int n, input logic [7:0] p);
    wr(`NPIC_OFF_PRIO + 12'(4 * n), {24'h0, p});
    wr(ES + 12'(n / 32 * 4), 32'h1 << (n % 32));
  endtask : cfg
  task automatic ex;
    @(posedge clk_i);
    exit_r <= 1'b1;
    @(posedge clk_i);
    exit_r <= 1'b0;
    repeat (16) @(posedge clk_i);
  endtask : ex
  // Bounded wait, a missing entry shows as a mismatch later
  task automatic wsv(input int n);
    repeat (40) if (served.size() < n) @(posedge clk_i);
  endtask : wsv
  function automatic logic [31:0] hexp(input int n);
    return (vbase | 32'(n * 4)) ^ 32'h5A5A_0000;
  endfunction : hexp
  task automatic conclude;
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    conclude();
  end
  initial begin
    seed = 32176;
    rst_i = 1'b1;
    bus = '0;
    src = '0;
    {nmi, slow, exit_r} = 3'h0;
    vbase = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (w = 0; w < 5; w++) begin
      r = $random(seed);
      wr(ES + 12'(4 * w), r);
      rc(`NPIC_OFF_ENCLR + 12'(4 * w), w == 4 ? r & 32'h03FF_FFFF : r);
      wr(`NPIC_OFF_ENCLR + 12'(4 * w), r);
      rc(ES + 12'(4 * w), 32'h0);
    end
    cfg(7, 8'hFF);
    wr(`NPIC_OFF_CTRL, 32'h1);
    wr(`NPIC_OFF_CTRL, 32'h0);
    rc(ES, 32'h80);
    rc(`NPIC_OFF_PRIO + 12'h01C, 32'hE0);
    rc(12'h3F0, 32'h0);
    src[7] <= 1'b1;
    nmi <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    chk(32'(nmi_o), 32'h1);
    src[7] <= 1'b0;
    nmi <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr(`NPIC_OFF_PNDCLR, 32'h80);
    rc(PS, 32'h0);
    wr(`NPIC_OFF_CTRL, 32'h1);
    src[9] <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    src[9] <= 1'b0;
    repeat (4) @(posedge clk_i);
    rc(PS, 32'h200);
    wr(`NPIC_OFF_PNDCLR, 32'h200);
    cfg(9, 8'h00);
    repeat (6) @(posedge clk_i);
    chk(32'(served.size()), 32'h0);
    wr(`NPIC_OFF_ENCLR, 32'h280);
    $display("Test masking done");
    for (int it = 0; it < 4; it++) begin
      w = it == 3 ? 4 : $unsigned($random(seed)) % 5;
      i = $unsigned($random(seed)) % 25;
      j = it == 3 ? 25 : i + 1 + $unsigned($random(seed)) % (25 - i);
      r = $random(seed);
      vbase = r & 32'hFFFF_FC00;
      slow <= r[0];
      wr(`NPIC_OFF_CTRL, {30'h0, it[0], 1'b1});
      wr(`NPIC_OFF_VBASE, vbase);
      cfg(32 * w + i, r[15:8]);
      cfg(32 * w + j, {r[15:13], ~r[12:8]});
      served.delete();
      wr(PS + 12'(4 * w), (32'h1 << i) | (32'h1 << j));
      wsv(1);
      chk(served[0], hexp(32 * w + i));
      chk(32'(tok), 32'h0);
      tail_seen = 1'b0;
      ex();
      chk(32'(tail_seen), 32'h1);
      wsv(2);
      chk(served[1], hexp(32 * w + j));
      tail_seen = 1'b0;
      ex();
      chk(32'(tail_seen), 32'h0);
      chk(32'(tok), 32'h1);
      rc(PS + 12'(4 * w), 32'h0);
      wr(`NPIC_OFF_ENCLR + 12'(4 * w), (32'h1 << i) | (32'h1 << j));
    end
    $display("Test ties done");
    cfg(20, 8'h60);
    cfg(40, 8'h3F);
    for (int g = 0; g < 4; g++) begin
      wr(`NPIC_OFF_GROUP, 32'(g));
      served.delete();
      pend(20);
      wsv(1);
      pend(40);
      repeat (20) @(posedge clk_i);
      chk(32'(served.size()), g < 2 ? 32'h2 : 32'h1);
      if (g > 1) ex();
      wsv(2);
      chk(served[1], hexp(40));
      ex();
      if (g < 2) ex();
      chk(32'(tok), 32'h1);
    end
    wr(`NPIC_OFF_GROUP, 32'h0);
    wr(`NPIC_OFF_THRESH, 32'h60);
    served.delete();
    pend(20);
    pend(40);
    wsv(1);
    repeat (10) @(posedge clk_i);
    chk(served[0], hexp(40));
    chk(32'(served.size()), 32'h1);
    $display("Test nesting done");
    conclude();
  end
endmodule : test_npic_ctrl
